// ==== bldcc_ctrl.v ====
`include "bldcc_defs.vh"
`default_nettype none
// Notes on behaviour
// - hall codes decode to a commutation step driving one of three high and one of three low switches.
// - overcurrent sets a latch that blanks the drive until the next ramp cycle start.
// - chip undervoltage, gate-drive undervoltage or reference loss turn all drive off.
// - a reference-loss input is a lockout that blanks the drive while asserted.
// - an invalid hall code or overtemperature blanks the drive.
// - fault_n is low while any fault is present and high otherwise.
// - drive is enabled while the demand level exceeds the ramp value.
// - faults and overcurrent override the pwm result.
// - the ramp rises each cycle, returns to zero, and marks each new cycle.
// - a spacing input selects the 60 or 120 degree decode table; windings need no change.
// - a fixed on-time speed pulse follows every hall edge.
// - six sensor edges per turn give six pulses per turn, one per edge.
// - there is no braking state; zero duty leaves all six drive outputs off.
module bldcc_ctrl #(
  parameter RAMP_W   = `BLDCC_RAMP_W,
  parameter TACH_W   = `BLDCC_TACH_W,
  parameter [RAMP_W-1:0] RAMP_TOP = `BLDCC_RAMP_TOP
) (
  input  wire              sys_clk,
  input  wire              reset,
  input  wire [2:0]        hall_in,
  input  wire              spacing_60,
  input  wire              reverse,
  input  wire [RAMP_W-1:0] demand,
  input  wire [TACH_W-1:0] tach_on_time,
  input  wire              over_current,
  input  wire              uv_chip,
  input  wire              uv_gate,
  input  wire              ref_lost,
  input  wire              over_temp,
  output reg  [2:0]        drive_hi_r,
  output reg  [2:0]        drive_lo_r,
  output reg               fault_n_r,
  output reg               cycle_start_r,
  output wire              tach_pulse
);
  reg  [2:0]        hall_s1_r;
  reg  [2:0]        hall_s2_r;
  reg  [2:0]        hall_d_r;
  reg  [2:0]        fill_r;
  reg  [RAMP_W-1:0] ramp_r;
  reg  [RAMP_W-1:0] ramp_nxt;
  reg               oc_latch_r;
  reg               oc_nxt;
  reg  [2:0]        drive_hi_nxt;
  reg  [2:0]        drive_lo_nxt;
  reg               fault_n_nxt;
  wire              ramp_wrap;
  wire              hall_ok;
  wire [6:0]        step;
  wire              code_bad;
  wire              lockout;
  wire              fault_any;
  wire              pwm_on;
  wire              blank;
  wire [2:0]        sensor_edge;
  wire              hall_edge;
  genvar            g;

  // 60 degree set: inverting the middle sensor gives the 120 degree code
  function [2:0] bldcc_map60;
    input [2:0] h;
    input       s60;
    begin
      if (s60)
        bldcc_map60 = h ^ 3'b010;
      else
        bldcc_map60 = h;
    end
  endfunction

  // decode a hall code into {valid, hi[2:0], lo[2:0]}
  function [6:0] bldcc_decode;
    input [2:0] h;
    input       s60;
    input       rev;
    reg   [2:0] c;
    reg   [6:0] v;
    begin
      c = bldcc_map60(h, s60);
      case (c)
        3'b001:  v = {1'b1, 3'b001, 3'b010};
        3'b011:  v = {1'b1, 3'b001, 3'b100};
        3'b010:  v = {1'b1, 3'b010, 3'b100};
        3'b110:  v = {1'b1, 3'b010, 3'b001};
        3'b100:  v = {1'b1, 3'b100, 3'b001};
        3'b101:  v = {1'b1, 3'b100, 3'b010};
        default: v = 7'h00;
      endcase
      if (rev)
        v = {v[6], v[2:0], v[5:3]};
      bldcc_decode = v;
    end
  endfunction

  // two-stage sync of hall inputs
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      hall_s1_r <= 3'h0;
      hall_s2_r <= 3'h0;
      hall_d_r  <= 3'h0;
      fill_r    <= 3'h0;
    end
    else
    begin
      hall_s1_r <= hall_in;
      hall_s2_r <= hall_s1_r;
      hall_d_r  <= hall_s2_r;
      fill_r    <= {fill_r[1:0], 1'b1};
    end
  end
  // fill_r marks the stages that hold a real sample, so the reset
  // value of the chain is neither decoded nor taken for an edge
  assign hall_ok = fill_r[1];

  // sawtooth: rise to top then snap to zero
  assign ramp_wrap = (ramp_r == RAMP_TOP);
  // next ramp value
  always @*
  begin
    ramp_nxt = ramp_r + {{(RAMP_W-1){1'b0}}, 1'b1};
    if (ramp_wrap)
      ramp_nxt = {RAMP_W{1'b0}};
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ramp_r        <= {RAMP_W{1'b0}};
      cycle_start_r <= 1'b0;
    end
    else
    begin
      ramp_r        <= ramp_nxt;
      cycle_start_r <= ramp_wrap;
    end
  end

  // overcurrent latch, set wins over cycle-start clear
  always @*
  begin
    oc_nxt = oc_latch_r;
    if (ramp_wrap)
      oc_nxt = 1'b0;
    if (over_current)
      oc_nxt = 1'b1;
  end
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      oc_latch_r <= 1'b0;
    else
      oc_latch_r <= oc_nxt;
  end

  // 60/120 table choice and commutation step
  assign step     = bldcc_decode(hall_s2_r, spacing_60, reverse);
  assign code_bad = hall_ok & ~step[6];
  assign lockout  = uv_chip | uv_gate | ref_lost;
  // demand above ramp enables drive; more demand, more duty
  assign pwm_on   = (demand > ramp_r);
  assign fault_any = oc_nxt | lockout | code_bad | over_temp;
  // any fault wins over pwm; zero duty just coasts
  assign blank     = fault_any | ~hall_ok | ~pwm_on;

  // next drive: off on any fault, lockout or ramp at or above demand
  always @*
  begin
    drive_hi_nxt = 3'h0;
    drive_lo_nxt = 3'h0;
    fault_n_nxt  = ~fault_any;
    if (!blank)
    begin
      drive_hi_nxt = step[5:3];
      drive_lo_nxt = step[2:0];
    end
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      drive_hi_r <= 3'h0;
      drive_lo_r <= 3'h0;
      fault_n_r  <= 1'b1;
    end
    else
    begin
      drive_hi_r <= drive_hi_nxt;
      drive_lo_r <= drive_lo_nxt;
      fault_n_r  <= fault_n_nxt;
    end
  end

  // one pulse per rising or falling edge of any sensor
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_edge
      assign sensor_edge[g] = fill_r[2] & (hall_s2_r[g] ^ hall_d_r[g]);
    end
  endgenerate
  assign hall_edge = |sensor_edge;

  bldcc_tach #(
    .TACH_W (TACH_W)
  ) u_tach (
    .sys_clk (sys_clk),
    .reset   (reset),
    .edge_in (hall_edge),
    .on_time (tach_on_time),
    .pulse_r (tach_pulse)
  );
endmodule
`default_nettype wire

// ==== bldcc_ctrl_assertions.sv ====
`default_nettype none
module bldcc_ctrl_chk (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [2:0] hall_in,
  input wire logic       spacing_60,
  input wire logic [7:0] demand,
  input wire logic       over_current,
  input wire logic       uv_chip,
  input wire logic       uv_gate,
  input wire logic       ref_lost,
  input wire logic       over_temp,
  input wire logic [2:0] drive_hi_r,
  input wire logic [2:0] drive_lo_r,
  input wire logic       fault_n_r,
  input wire logic       cycle_start_r,
  input wire logic       tach_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic flt = uv_chip | uv_gate | ref_lost | over_temp;
  wire logic off = (drive_hi_r == 3'h0) && (drive_lo_r == 3'h0);
  sequence s_oc_held;
    over_current ##1 !cycle_start_r [*2];
  endsequence
  sequence s_bad;
    (spacing_60 ? (hall_in == 3'h2 || hall_in == 3'h5)
                : (hall_in == 3'h0 || hall_in == 3'h7)) [*3];
  endsequence
  a_flt_blank: assert property (flt |=> off)
    else $error("drive on in lockout");
  a_flt_flag: assert property (flt |=> !fault_n_r)
    else $error("fault flag not low");
  a_flt_rel: assert property ($rose(fault_n_r) |-> !$past(flt))
    else $error("fault flag released early");
  a_oc_hold: assert property (s_oc_held |-> off)
    else $error("drive on in overcurrent cycle");
  a_bad_code: assert property (s_bad |=> off)
    else $error("drive on with bad code");
  a_zero_duty: assert property (demand == 8'h00 |=> off)
    else $error("drive on at zero demand");
  a_one_phase: assert property ((drive_hi_r & drive_lo_r) == 3'h0
    && $onehot0(drive_hi_r) && $onehot0(drive_lo_r))
    else $error("bad phase pattern");
  a_tach_edge: assert property ($changed(hall_in)
    |-> ##3 tach_pulse)
    else $error("no speed pulse");
  a_cycle_one: assert property (cycle_start_r
    |=> !cycle_start_r)
    else $error("cycle mark too long");
endmodule
`default_nettype wire

// ==== bldcc_ctrl_tb_top.sv ====
`default_nettype none
module bldcc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, reset = 1, step = 0, bad = 0, over_current = 0;
  logic uv_chip = 0, uv_gate = 0, ref_lost = 0, over_temp = 0;
  logic spacing_60 = 0, reverse = 0, tach_d = 0;
  logic [7:0]  demand = 8'hFF;
  logic [5:0]  drv;
  logic [15:0] tach_on_time = 16'h0005;
  wire logic [2:0] hall_in, drive_hi_r, drive_lo_r;
  wire logic fault_n_r, cycle_start_r, tach_pulse;
  int n_mismatch = 0, n_compared = 0, npulse, nhigh, non, i, k;
  bldcc_ctrl #(.RAMP_TOP(8'h0F)) dut (.*);
  bldcc_hall_model hm (.*);
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    nhigh += tach_pulse;
    npulse += tach_pulse && !tach_d;
    tach_d = tach_pulse;
  end
  task cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wcs;
    for (k = 0; k < 40 && cycle_start_r !== 1'b1; k++) cyc(1);
    if (k == 40)
    begin
      n_mismatch++;
      test_done;
    end
  endtask
  initial
  begin
    cyc(6);
    reset <= 0;
    cyc(10);
    npulse = 0;
    nhigh = 0;
    for (i = 0; i < 12; i++)
    begin
      step <= 1;
      cyc(1);
      step <= 0;
      cyc(10);
      chk("phase", {$onehot(drive_hi_r), $onehot(drive_lo_r),
                    ~|(drive_hi_r & drive_lo_r)}, 3'h7);
    end
    chk("pulses", npulse, 12);
    chk("width", nhigh, 60);
    for (i = 0; i < 5; i++)
    begin
      {uv_chip, uv_gate, ref_lost, over_temp} <= 4'h1 << i;
      bad <= (i == 4);
      cyc(5);
      chk("flt_off", {drive_hi_r, drive_lo_r}, 0);
      chk("flt_n", fault_n_r, 0);
      {uv_chip, uv_gate, ref_lost, over_temp, bad} <= 5'h00;
      cyc(5);
      chk("flt_rel", fault_n_r, 1);
    end
    drv = {drive_hi_r, drive_lo_r};
    reverse <= 1;
    cyc(3);
    chk("rev", {drive_hi_r, drive_lo_r}, {drv[2:0], drv[5:3]});
    reverse <= 0;
    spacing_60 <= 1;
    bad <= 1;
    cyc(5);
    chk("s60_ok", {fault_n_r, $onehot(drive_lo_r)}, 2'h3);
    spacing_60 <= 0;
    cyc(5);
    chk("s120_bad", fault_n_r, 0);
    bad <= 0;
    cyc(5);
    wcs;
    cyc(2);
    over_current <= 1;
    cyc(1);
    over_current <= 0;
    cyc(2);
    chk("oc_off", {drive_hi_r, drive_lo_r}, 0);
    wcs;
    cyc(3);
    chk("oc_clr", drive_lo_r != 0, 1);
    wcs;
    cyc(1);
    wcs;
    chk("period", k + 1, 16'h0010);
    for (i = 0; i < 3; i++)
    begin
      demand <= 8'h08 * i;
      wcs;
      cyc(2);
      non = 0;
      repeat (16) begin cyc(1); non += (drive_lo_r != 0); end
      chk("duty", non, 8 * i);
    end
    test_done;
  end
endmodule
bind bldcc_ctrl bldcc_ctrl_chk chk_i (.*);
`default_nettype wire

// ==== bldcc_defs.vh ====
`ifndef BLDCC_DEFS_VH
`define BLDCC_DEFS_VH
// ramp and demand width
`define BLDCC_RAMP_W        8
// default ramp top count; period is top+1 clocks (ramp counts 0 .. top)
`define BLDCC_RAMP_TOP      8'hFF
// speed pulse on-time in clocks
`define BLDCC_TACH_ON       16'h0010
`define BLDCC_TACH_W        16
// sensor spacing select values
`define BLDCC_SPACE_120     1'b0
`define BLDCC_SPACE_60      1'b1
// drive vector bit positions: {hi_c,hi_b,hi_a,lo_c,lo_b,lo_a}
`define BLDCC_LO_A          0
`define BLDCC_HI_A          3
`endif

// ==== bldcc_hall_model.sv ====
`default_nettype none
module bldcc_hall_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       step,
  input  wire logic       bad,
  output wire logic [2:0] hall_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pos_r;
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  // one sensor edge per step, six per electrical turn
  always @(posedge sys_clk or posedge reset)
    if (reset) pos_r <= 3'h0;
    else if (step) pos_r <= (pos_r == 3'h5) ? 3'h0 : pos_r + 3'h1;
  assign hall_in = bad ? 3'h7 : seq[pos_r];
endmodule
`default_nettype wire

// ==== bldcc_tach.v ====
`include "bldcc_defs.vh"
`default_nettype none
module bldcc_tach #(
  parameter TACH_W = `BLDCC_TACH_W
) (
  input  wire              sys_clk,
  input  wire              reset,
  input  wire              edge_in,
  input  wire [TACH_W-1:0] on_time,
  output reg               pulse_r
);
  reg [TACH_W-1:0] cnt_r;
  reg [TACH_W-1:0] cnt_nxt;

  always @*
  begin
    cnt_nxt = cnt_r;
    if (edge_in)
      cnt_nxt = on_time;
    else if (cnt_r != {TACH_W{1'b0}})
      cnt_nxt = cnt_r - {{(TACH_W-1){1'b0}}, 1'b1};
  end

  // fixed on-time pulse, retriggered by each edge
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r   <= {TACH_W{1'b0}};
      pulse_r <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      pulse_r <= (cnt_nxt != {TACH_W{1'b0}});
    end
  end
endmodule
`default_nettype wire
